/* pfc_pkg.sv */
package pfc_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   // command codes and unlock addresses
   localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
   localparam logic [10:0] UNLOCK_ADDR2 = 11'h2AA;
   localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
   localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0]  CMD_ID       = 8'h90;
   localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
   localparam logic [7:0]  CMD_ERASE    = 8'h80;
   localparam logic [7:0]  CMD_CHIP_ER  = 8'h10;
   localparam logic [7:0]  CMD_SECT_ER  = 8'h30;
   localparam logic [7:0]  CMD_RESET    = 8'hF0;
   localparam logic [7:0]  CMD_BYP_ENT  = 8'h20;
   localparam logic [7:0]  CMD_BYP_EXIT = 8'h00;
   localparam logic [7:0]  CMD_BYP_RST  = 8'h90;
   localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 20'h00000;
   localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 20'h00001;
   // timing, ns and cycles at 25 MHz
   localparam int CLK_NS          = 40;
   localparam int T_ACCESS_NS     = 90;
   localparam int T_WPULSE_NS     = 50;
   localparam int T_RECOVER_NS    = 30;
   localparam int RESET_PULSE_MIN_NS = 500;
   localparam int RESET_HIGH_TO_READ_NS = 50;
   localparam int ACC_CYC  = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC   = (T_WPULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int REC_CYC  = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam int RP_CYC   = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RH_CYC   = (RESET_HIGH_TO_READ_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W    = 8;
   // host operations
   typedef enum logic [3:0] {
      OP_READ     = 4'h0,
      OP_PROGRAM  = 4'h1,
      OP_BYP_PROG = 4'h2,
      OP_BYP_ENT  = 4'h3,
      OP_BYP_EXIT = 4'h4,
      OP_CHIP_ER  = 4'h5,
      OP_SECT_ER  = 4'h6,
      OP_ID_ENT   = 4'h7,
      OP_RESET    = 4'h8,
      OP_HW_RESET = 4'h9
   } pfc_op_type;
   typedef struct packed {
      pfc_op_type        op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pfc_req_type;
   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              rst_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
      logic              dq_oe;
   } pfc_pins_type;
endpackage

/* pfc_sync.sv */
`timescale 1ns/1ps
module pfc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         arst_n_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_r;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_r <= '0;
         q_out  <= '0;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule // pfc_sync

/* pfc_host.sv */
`timescale 1ns/1ps
// Overview of operation
// - reads drive chip select and output enable low, write strobe high
// - writes drive write strobe and chip select low, output enable high
// - host waits reset-high-to-read before reading; may watch ready/busy
// - host should reissue operations interrupted by hardware reset
// - reset command byte aborts failure; host then writes valid command
// - id mode held until the reset command is written or a hardware reset is pulsed
module pfc_host
   import pfc_pkg::*;
(
   // clock and reset
   input  wire logic               mclk_in,
   input  wire logic               arst_n_in,
   // request port
   input  wire logic               req_valid_in,
   input  pfc_pkg::pfc_req_type    req_in,
   output logic                    req_ready_out,
   output logic                    done_out,
   output logic [pfc_pkg::DATA_W-1:0] rdata_out,
   output logic                    busy_out,
   // flash pins
   output logic                    ce_n_out,
   output logic                    oe_n_out,
   output logic                    we_n_out,
   output logic                    rst_n_out,
   output logic [pfc_pkg::ADDR_W-1:0] addr_out,
   output logic [pfc_pkg::DATA_W-1:0] dq_out,
   output logic                    dq_oe_out,
   input  wire logic [pfc_pkg::DATA_W-1:0] dq_in,
   input  wire logic               ready_busy_n_in
);
   import pfc_pkg::*;

   typedef enum logic [6:0] {
      ST_IDLE  = 7'b0000001,
      ST_RDACC = 7'b0000010,
      ST_WLOW  = 7'b0000100,
      ST_WREC  = 7'b0001000,
      ST_RSTLO = 7'b0010000,
      ST_RSTHI = 7'b0100000,
      ST_DONE  = 7'b1000000
   } pfc_state_type;

   pfc_state_type     state_r;
   logic [CNT_W-1:0]  cnt_r;
   logic [2:0]        step_r;
   logic [2:0]        nsteps_r;
   pfc_req_type       cur_r;
   logic [DATA_W-1:0] dq_sync;
   logic              busy_sync;
   logic [ADDR_W-1:0] seq_addr;
   logic [DATA_W-1:0] seq_data;

   pfc_sync #(.W(DATA_W + 1)) u_sync (
      .mclk_in   (mclk_in),
      .arst_n_in (arst_n_in),
      // busy carried inverted so the reset value matches an idle pin
      .d_in      ({~ready_busy_n_in, dq_in}),
      .q_out     ({busy_sync, dq_sync})
   );

   // cycle list per operation; upper address bits are zero on unlock cycles
   always_comb begin
      seq_addr = {9'h000, UNLOCK_ADDR1};
      seq_data = UNLOCK_DATA1;
      unique case (cur_r.op)
         OP_PROGRAM: begin
            // standard program: two unlocks, command, data
            unique case (step_r)
               3'h0: ;
               3'h1: begin
                  seq_addr = {9'h000, UNLOCK_ADDR2};
                  seq_data = UNLOCK_DATA2;
               end
               3'h2: seq_data = CMD_PROGRAM;
               default: begin
                  seq_addr = cur_r.addr;
                  seq_data = cur_r.data;
               end
            endcase
         end
         OP_BYP_PROG: begin
            // two writes only in bypass mode
            if (step_r == 3'h0) begin
               seq_data = CMD_PROGRAM;
            end else begin
               seq_addr = cur_r.addr;
               seq_data = cur_r.data;
            end
         end
         OP_BYP_EXIT: begin
            seq_addr = cur_r.addr;
            seq_data = (step_r == 3'h0) ? CMD_BYP_RST : CMD_BYP_EXIT;
         end
         OP_RESET: begin
            seq_addr = cur_r.addr; // any address works
            seq_data = CMD_RESET;
         end
         default: begin
            // unlock, unlock, command [, unlock, unlock, final]
            unique case (step_r)
               3'h0, 3'h3: ;
               3'h1, 3'h4: begin
                  seq_addr = {9'h000, UNLOCK_ADDR2};
                  seq_data = UNLOCK_DATA2;
               end
               3'h2: begin
                  unique case (cur_r.op)
                     OP_ID_ENT:  seq_data = CMD_ID;
                     OP_BYP_ENT: seq_data = CMD_BYP_ENT;
                     default:    seq_data = CMD_ERASE;
                  endcase
               end
               default: begin
                  if (cur_r.op == OP_SECT_ER) begin
                     seq_addr = cur_r.addr; // sector address
                     seq_data = CMD_SECT_ER;
                  end else begin
                     seq_data = CMD_CHIP_ER;
                  end
               end
            endcase
         end
      endcase
   end

   function automatic logic [2:0] op_steps(input pfc_op_type op);
      unique case (op)
         OP_PROGRAM:              op_steps = 3'h4;
         OP_BYP_PROG, OP_BYP_EXIT: op_steps = 3'h2;
         OP_CHIP_ER, OP_SECT_ER:  op_steps = 3'h6;
         OP_ID_ENT, OP_BYP_ENT:   op_steps = 3'h3;
         default:                 op_steps = 3'h1;
      endcase
   endfunction

   // sequencer
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r  <= ST_IDLE;
         cnt_r    <= '0;
         step_r   <= '0;
         nsteps_r <= '0;
         cur_r    <= '0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (req_valid_in) begin
                  cur_r    <= req_in;
                  step_r   <= '0;
                  nsteps_r <= op_steps(req_in.op);
                  unique case (req_in.op)
                     OP_READ: begin
                        state_r <= ST_RDACC;
                        cnt_r   <= CNT_W'(ACC_CYC + 2);
                     end
                     OP_HW_RESET: begin
                        state_r <= ST_RSTLO;
                        cnt_r   <= CNT_W'(RP_CYC);
                     end
                     default: begin
                        state_r <= ST_WLOW;
                        cnt_r   <= CNT_W'(WP_CYC);
                     end
                  endcase
               end
            end
            ST_RDACC: begin
               // wait covers access time plus the input synchroniser
               if (cnt_r == '0) state_r <= ST_DONE;
               else cnt_r <= cnt_r - 1'b1;
            end
            ST_WLOW: begin
               if (cnt_r == '0) begin
                  state_r <= ST_WREC;
                  cnt_r   <= CNT_W'(REC_CYC);
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            ST_WREC: begin
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - 1'b1;
               end else if (step_r + 3'h1 == nsteps_r) begin
                  state_r <= ST_DONE;
               end else begin
                  step_r  <= step_r + 3'h1;
                  state_r <= ST_WLOW;
                  cnt_r   <= CNT_W'(WP_CYC);
               end
            end
            ST_RSTLO: begin
               // hold reset the minimum pulse width
               if (cnt_r == '0) begin
                  state_r <= ST_RSTHI;
                  cnt_r   <= CNT_W'(RH_CYC);
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            ST_RSTHI: begin
               // wait reset-high-to-read and for ready
               // done only once ready, so a reissued sequence lands
               if (cnt_r != '0) cnt_r <= cnt_r - 1'b1;
               else if (!busy_sync) state_r <= ST_DONE;
            end
            ST_DONE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // pin drive
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ce_n_out  <= 1'b1;
         oe_n_out  <= 1'b1;
         we_n_out  <= 1'b1;
         rst_n_out <= 1'b0;
         addr_out  <= '0;
         dq_out    <= '0;
         dq_oe_out <= 1'b0;
      end else begin
         rst_n_out <= (state_r != ST_RSTLO);
         unique case (state_r)
            ST_RDACC: begin
               ce_n_out  <= 1'b0;
               oe_n_out  <= 1'b0;
               we_n_out  <= 1'b1;
               dq_oe_out <= 1'b0;
               addr_out  <= cur_r.addr;
            end
            ST_WLOW: begin
               ce_n_out  <= 1'b0;
               oe_n_out  <= 1'b1;
               we_n_out  <= 1'b0;
               dq_oe_out <= 1'b1;
               addr_out  <= seq_addr;
               dq_out    <= seq_data;
            end
            ST_WREC: begin
               // data held one phase past the rising strobe;
               // chip select stays low so the strobe edge alone ends it
               we_n_out <= 1'b1;
               oe_n_out <= 1'b1;
            end
            default: begin
               ce_n_out  <= 1'b1;
               oe_n_out  <= 1'b1;
               we_n_out  <= 1'b1;
               dq_oe_out <= 1'b0;
            end
         endcase
      end
   end

   // status to the requester
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         req_ready_out <= 1'b0;
         done_out      <= 1'b0;
         rdata_out     <= '0;
         busy_out      <= 1'b0;
      end else begin
         req_ready_out <= (state_r == ST_IDLE) && !req_valid_in;
         done_out      <= (state_r == ST_DONE);
         busy_out      <= busy_sync;
         if (state_r == ST_RDACC && cnt_r == '0) rdata_out <= dq_sync;
      end
   end
endmodule // pfc_host

/* pfc_flash_model.sv */
`timescale 1ns/1ps
module pfc_flash_model #(
   parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h6C, // arbitrary value
   parameter int         BUSY_NS  = 2000,
   parameter int         READY_NS = 400
) (
   // strobes and address
   input  wire logic        ce_n_in,
   input  wire logic        oe_n_in,
   input  wire logic        we_n_in,
   input  wire logic        rst_n_in,
   input  wire logic [19:0] addr_in,
   input  wire logic [7:0]  dq_in,
   input  wire logic        elevated_id_voltage_in,
   // data and status
   output logic [7:0]       q_out,
   output logic             q_en_out,
   output logic             ready_busy_n_out
);
   logic [7:0]       mem [0:20'hFFFFF];
   int               st = 0;
   bit               id_r = 0;
   bit               byp_r = 0;
   wire logic [10:0] lo = addr_in[10:0];
   initial begin
      ready_busy_n_out = 1'b1;
      foreach (mem[i]) mem[i] = 8'hFF;
   end
   assign q_en_out = !ce_n_in && !oe_n_in && rst_n_in;
   assign q_out = !(id_r || elevated_id_voltage_in) ? mem[addr_in] :
                  addr_in[0] ? DEV_CODE : MFR_CODE;
   // embedded work ignores chip select once started
   task automatic busy();
      ready_busy_n_out <= 1'b0;
      ready_busy_n_out <= #(BUSY_NS) 1'b1;
   endtask
   always @(posedge we_n_in) begin
      if (!ce_n_in && oe_n_in && rst_n_in) begin
         if (dq_in == 8'hF0 && !byp_r) begin
            st = 0;
            id_r = 0;
         end else if (byp_r) begin
            if (st == 7) mem[addr_in] &= dq_in;
            if (st == 7) busy();
            if (st == 8) byp_r = dq_in != 8'h00;
            st = st != 0 ? 0 : dq_in == 8'hA0 ? 7 : dq_in == 8'h90 ? 8 : 0;
         end else case (st)
            0: st = (lo == 11'h555 && dq_in == 8'hAA) ? 1 : 0;
            1: st = (lo == 11'h2AA && dq_in == 8'h55) ? 2 : 0;
            2: begin
               st = 0;
               if (lo == 11'h555 && dq_in == 8'h90) id_r = 1;
               if (lo == 11'h555 && dq_in == 8'h20) byp_r = 1;
               if (lo == 11'h555 && dq_in == 8'hA0) st = 3;
               if (lo == 11'h555 && dq_in == 8'h80) st = 4;
            end
            3: begin
               mem[addr_in] &= dq_in;
               busy();
               st = 0;
            end
            4: st = (lo == 11'h555 && dq_in == 8'hAA) ? 5 : 0;
            5: st = (lo == 11'h2AA && dq_in == 8'h55) ? 6 : 0;
            default: begin
               // sectors taken as 64K blocks by the top address bits
               if (lo == 11'h555 && dq_in == 8'h10)
                  foreach (mem[i]) mem[i] = 8'hFF;
               if (dq_in == 8'h30)
                  for (int i = 0; i < 65536; i++)
                     mem[{addr_in[19:16], i[15:0]}] = 8'hFF;
               busy();
               st = 0;
            end
         endcase
      end
   end
   always @(negedge rst_n_in) begin
      st = 0;
      id_r = 0;
      byp_r = 0;
      if (!ready_busy_n_out) ready_busy_n_out <= #(READY_NS) 1'b1;
   end
endmodule // pfc_flash_model

/* pfc_host_chk.sv */
`timescale 1ns/1ps
module pfc_host_chk
   import pfc_pkg::*;
(
   // clock and reset
   input  wire logic                       mclk_in,
   input  wire logic                       arst_n_in,
   // flash pins
   input  wire logic                       ce_n_out,
   input  wire logic                       oe_n_out,
   input  wire logic                       we_n_out,
   input  wire logic                       rst_n_out,
   input  wire logic [pfc_pkg::ADDR_W-1:0] addr_out,
   input  wire logic [pfc_pkg::DATA_W-1:0] dq_out,
   input  wire logic                       dq_oe_out
);
   logic [7:0] low_cnt_r;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   // FF marks power-on release, which needs no minimum low time
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) low_cnt_r <= 8'hFF;
      else if (rst_n_out) low_cnt_r <= 8'h00;
      else if (low_cnt_r < 8'hFE) low_cnt_r <= low_cnt_r + 8'h01;
   end
   sequence wr_pulse_s;
      !we_n_out [*3] ##1 we_n_out;
   endsequence
   sequence rd_gap_s;
      oe_n_out [*2];
   endsequence
   read_strobe_a: assert property (
      !oe_n_out |-> !ce_n_out && we_n_out) else $error("bad read strobes");
   read_hold_a: assert property (
      !oe_n_out && !$past(oe_n_out) |-> $stable(addr_out))
      else $error("read address moved");
   write_strobe_a: assert property (
      !we_n_out |-> !ce_n_out && oe_n_out && dq_oe_out)
      else $error("bad write strobes");
   we_width_a: assert property (
      $fell(we_n_out) |-> wr_pulse_s) else $error("write pulse width");
   write_hold_a: assert property (
      !we_n_out && !$past(we_n_out) |-> $stable(addr_out) && $stable(dq_out))
      else $error("write data moved");
   no_contend_a: assert property (
      dq_oe_out |-> oe_n_out) else $error("data bus contention");
   reset_width_a: assert property (
      $rose(rst_n_out) |-> low_cnt_r >= 8'(RP_CYC))
      else $error("flash reset too short");
   read_gap_a: assert property (
      $rose(rst_n_out) && low_cnt_r != 8'hFF |-> rd_gap_s)
      else $error("read too soon after reset");
endmodule // pfc_host_chk
bind pfc_host pfc_host_chk i_chk (
   .mclk_in, .arst_n_in, .ce_n_out, .oe_n_out, .we_n_out, .rst_n_out,
   .addr_out, .dq_out, .dq_oe_out
);

/* test_parallel_flash_bus_mode_control.sv */
`timescale 1ns/1ps
module test_parallel_flash_bus_mode_control;
   import pfc_pkg::*;
   localparam logic [7:0] MFR = 8'h5A; // arbitrary value
   localparam logic [7:0] DEV = 8'h6C; // arbitrary value
   logic        mclk_in = 0, arst_n_in = 0, req_valid_in = 0;
   pfc_req_type req_in = '0;
   logic        req_ready_out, done_out, busy_out, ce_n_out, oe_n_out;
   logic        we_n_out, rst_n_out, dq_oe_out, f_en, ready_busy_n_in;
   logic [19:0] addr_out;
   logic [7:0]  rdata_out, dq_out, f_q, dq_in;
   logic [7:0]  ref_mem [int];
   logic [31:0] seed = 32'h154F;
   int          fail_count = 0, n_tests = 0;
   bit          id_r = 0;
   bit          elevated_id_voltage = 0;
   // undriven bus shows the inverse of the last driven byte, not that byte held
   assign dq_in = dq_oe_out ? dq_out : f_en ? f_q : ~dq_out;
   always #20 mclk_in = ~mclk_in;
   pfc_host i_dut (.mclk_in, .arst_n_in, .req_valid_in, .req_in,
      .req_ready_out, .done_out, .rdata_out, .busy_out, .ce_n_out,
      .oe_n_out, .we_n_out, .rst_n_out, .addr_out, .dq_out, .dq_oe_out,
      .dq_in, .ready_busy_n_in);
   pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_flash (
      .ce_n_in(ce_n_out), .oe_n_in(oe_n_out), .we_n_in(we_n_out),
      .rst_n_in(rst_n_out), .addr_in(addr_out), .dq_in(dq_in),
      .elevated_id_voltage_in(elevated_id_voltage), .q_out(f_q),
      .q_en_out(f_en), .ready_busy_n_out(ready_busy_n_in));
   task automatic end_of_test();
      if (fail_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic void step();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] exp_rd(input logic [19:0] a);
      if (id_r || elevated_id_voltage) return a[0] ? DEV : MFR;
      return ref_mem.exists(a) ? ref_mem[a] : 8'hFF;
   endfunction
   task automatic run(input pfc_op_type op, input logic [19:0] a,
                      input logic [7:0] d);
      int n = 0;
      @(negedge mclk_in);
      while (req_ready_out !== 1'b1 && n++ < 50) @(negedge mclk_in);
      check({7'h00, req_ready_out}, 8'h01);
      req_in = '{op, a, d};
      req_valid_in = 1;
      @(negedge mclk_in);
      req_valid_in = 0;
      n = 0;
      while (done_out !== 1'b1 && n++ < 4000) @(negedge mclk_in);
      check({7'h00, done_out}, 8'h01);
   endtask
   task automatic settle();
      int n = 0;
      repeat (4) @(negedge mclk_in);
      check({7'h00, busy_out}, 8'h01);
      while (busy_out !== 1'b0 && n++ < 3000) @(negedge mclk_in);
      check({7'h00, busy_out}, 8'h00);
   endtask
   task automatic rd(input logic [19:0] a);
      run(OP_READ, a, 8'h00);
      check(rdata_out, exp_rd(a));
   endtask
   task automatic pg(input pfc_op_type op, input logic [19:0] a,
                     input logic [7:0] d);
      run(op, a, d);
      ref_mem[a] = exp_rd(a) & d;
      settle();
   endtask
   initial begin
      logic [19:0] a, a2;
      repeat (8) @(negedge mclk_in);
      arst_n_in = 1;
      step();
      a = seed[19:0];
      a2 = a ^ 20'h80000;
      rd(a);
      pg(OP_PROGRAM, a, seed[27:20]);
      rd(a);
      run(OP_BYP_PROG, a, 8'h12);
      rd(a);
      run(OP_ID_ENT, a2, 8'h00);
      id_r = 1;
      rd({seed[17:0], 2'b00});
      rd({seed[19:2], 2'b01});
      run(OP_RESET, seed[19:0] ^ 20'h5A5A5, 8'h00);
      id_r = 0;
      rd(a);
      run(OP_BYP_ENT, a, 8'h00);
      for (int i = 0; i < 3; i++) begin
         step();
         pg(OP_BYP_PROG, seed[19:0], seed[31:24]);
         rd(seed[19:0]);
      end
      run(OP_BYP_EXIT, a, 8'h00);
      pg(OP_PROGRAM, a2, 8'h3C);
      run(OP_SECT_ER, a, 8'h00);
      settle();
      for (int i = 0; i < 65536; i++)
         if (ref_mem.exists({a[19:16], i[15:0]}))
            ref_mem.delete({a[19:16], i[15:0]});
      rd(a);
      rd(a2);
      run(OP_CHIP_ER, a, 8'h00);
      settle();
      ref_mem.delete();
      rd(a2);
      elevated_id_voltage = 1;
      rd({a2[19:2], 2'b00});
      rd({a2[19:2], 2'b01});
      elevated_id_voltage = 0;
      run(OP_ID_ENT, a, 8'h00);
      run(OP_HW_RESET, a, 8'h00);
      rd(a2);
      run(OP_PROGRAM, a, 8'h0F);
      repeat (4) @(negedge mclk_in);
      check({7'h00, busy_out}, 8'h01);
      run(OP_HW_RESET, a, 8'h00);
      check({7'h00, busy_out}, 8'h00);
      rd(a2);
      pg(OP_PROGRAM, a, 8'h0F);
      rd(a);
      end_of_test();
   end
   // whole sequence needs well under 10000 cycles
   initial begin
      #(40 * 20000);
      fail_count++;
      end_of_test();
   end
endmodule // test_parallel_flash_bus_mode_control
